// *** sbd_core.sv ***
// sign widen, packed bcd adjust and minus-one datapath slice
// assumes an apb master on clk; operands staged in registers by software
//
// Functional notes
// - 16-bit widen copies accumulator bit 15 into all extension word bits.
// - 32-bit widen copies accumulator bit 31 into all extension bits.
// - opcode 99 for both widens; size attribute picks; no flags, no faults.
// - bcd adjusts use only the accumulator low byte, never fault.
// - add adjust low digit: over 9 or aux set adds 6, sets aux.
// - add adjust high digit: high bits over 90 or carry adds 60, sets carry.
// - add adjust sets sign, zero, parity from result; overflow left as is.
// - sub adjust low digit: over 9 or aux set subtracts 6, sets aux.
// - sub adjust high digit: byte over 9f or carry subtracts 60.
// - sub adjust sets sign, zero, parity from result; overflow left.
// - minus-one subtracts one, writes back, keeps carry unchanged.
// - minus-one sets overflow, sign, zero, aux and parity from result.
// - minus-one decodes as fe /1, ff /1 and 48 plus register.
// - protected mode, non-writable destination gives protection fault code 0.
// - segment limit overrun faults; null selector faults in protected mode.
// - protected mode null data selector gives protection fault code 0.
// - stack segment limit overrun gives stack fault in all modes.
// - alignment fault when enabled: protected at level 3, always in v86.
// - page fault with fault code in protected and v86 modes.
// - feature-query flag is writable both ways when implemented, else fixed.
`timescale 1ns/1ns
`include "sbd_regs_regs.svh"

module sbd_core
  import sbd_pkg::*;
#(
  parameter logic FEATURE_QUERY_IMPL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  //////////////////////////////////////////////////////////////////////
  // state

  logic [31:0] acc_r;
  logic [31:0] ext_r;
  logic [31:0] opnd_r;
  logic [31:0] flags_r;
  sbd_cmd_type cmd_r;
  sbd_ctx_type ctx_r;
  sbd_fault_type fault_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic [31:0] acc_nxt;
  logic [31:0] ext_nxt;
  logic [31:0] opnd_nxt;
  logic [31:0] flags_nxt;
  sbd_fault_type fault_nxt;

  //////////////////////////////////////////////////////////////////////
  // apb decode

  // one wait-free access: pready rises in the first access cycle
  wire logic setup_ph = psel & ~penable;
  wire logic xfer_done = psel & penable & pready_r;
  wire logic wr_en = xfer_done & pwrite;

  wire logic hit_cmd = paddr == `SBD_ADDR_CMD;
  wire logic hit_acc = paddr == `SBD_ADDR_ACC;
  wire logic hit_ext = paddr == `SBD_ADDR_EXT;
  wire logic hit_opnd = paddr == `SBD_ADDR_OPND;
  wire logic hit_flags = paddr == `SBD_ADDR_FLAGS;
  wire logic hit_ctx = paddr == `SBD_ADDR_CTX;
  wire logic hit_fault = paddr == `SBD_ADDR_FAULT;
  wire logic addr_hit = hit_cmd | hit_acc | hit_ext | hit_opnd |
                        hit_flags | hit_ctx | hit_fault;

  wire logic [31:0] rd_mux =
    hit_cmd ? cmd_r :
    hit_acc ? acc_r :
    hit_ext ? ext_r :
    hit_opnd ? opnd_r :
    hit_flags ? flags_r :
    hit_ctx ? ctx_r :
    hit_fault ? fault_r : 32'h0000_0000;

  wire logic exec = wr_en & hit_cmd;
  wire sbd_cmd_type cmd_w = pwdata;

  // one strobe per staged register; fault is read only, so it has none
  wire logic wr_acc = wr_en & hit_acc;
  wire logic wr_ext = wr_en & hit_ext;
  wire logic wr_opnd = wr_en & hit_opnd;
  wire logic wr_flags = wr_en & hit_flags;
  wire logic wr_ctx = wr_en & hit_ctx;

  // the answer is fixed at setup, so a late paddr change cannot alter it
  wire logic pready_nxt = setup_ph;
  wire logic pslverr_nxt = setup_ph & ~addr_hit;
  wire logic [31:0] prdata_nxt = pwrite ? 32'h0000_0000 : rd_mux;

  //////////////////////////////////////////////////////////////////////
  // instruction decode

  wire logic opc_dec_m = (cmd_w.opcode == `SBD_OPC_DEC_B |
                          cmd_w.opcode == `SBD_OPC_DEC_V) &
                         cmd_w.reg_fld == `SBD_MODRM_DEC;
  wire logic opc_dec_r = cmd_w.opcode[7:3] == `SBD_OPC_DEC_R;
  wire logic dec_byte = cmd_w.opcode == `SBD_OPC_DEC_B;
  // short form is register only, so it never touches memory
  wire logic dec_mem = opc_dec_m & cmd_w.mem;

  wire sbd_op_type op_sel =
    cmd_w.opcode == `SBD_OPC_WIDEN ? SBD_OP_WIDEN :
    cmd_w.opcode == `SBD_OPC_DAA ? SBD_OP_DAA :
    cmd_w.opcode == `SBD_OPC_DAS ? SBD_OP_DAS :
    (opc_dec_m | opc_dec_r) ? SBD_OP_DEC : SBD_OP_NONE;

  //////////////////////////////////////////////////////////////////////
  // sign widen

  // the word form leaves the upper half of the extension alone
  wire logic [31:0] widen_ext = cmd_w.size32 ?
    {32{acc_r[31]}} :
    {ext_r[31:16], {16{acc_r[15]}}};

  //////////////////////////////////////////////////////////////////////
  // bcd adjust of the accumulator low byte

  wire logic [7:0] al = acc_r[7:0];
  wire logic cf_in = flags_r[`SBD_FLG_CF];
  wire logic af_in = flags_r[`SBD_FLG_AF];
  wire logic lo_fix = (al[3:0] > `SBD_DIGIT_MAX) | af_in;

  wire logic [8:0] daa_lo_sum = {1'b0, al} + {1'b0, `SBD_LO_ADJ};
  wire logic [7:0] daa_al1 = lo_fix ? daa_lo_sum[7:0] : al;
  wire logic daa_cf1 = lo_fix ? (cf_in | daa_lo_sum[8]) : cf_in;
  wire logic daa_hi_fix = ((daa_al1 & `SBD_HI_MASK) > `SBD_DAA_HI_MAX) |
                          daa_cf1;
  wire logic [7:0] daa_res = daa_hi_fix ?
    daa_al1 + `SBD_HI_ADJ : daa_al1;

  wire logic [8:0] das_lo_dif = {1'b0, al} - {1'b0, `SBD_LO_ADJ};
  wire logic [7:0] das_al1 = lo_fix ? das_lo_dif[7:0] : al;
  wire logic das_cf1 = lo_fix ? (cf_in | das_lo_dif[8]) : cf_in;
  wire logic das_hi_fix = (das_al1 > `SBD_DAS_HI_MAX) | das_cf1;
  wire logic [7:0] das_res = das_hi_fix ?
    das_al1 - `SBD_HI_ADJ : das_al1;

  // sign, zero and parity only look at the adjusted byte
  wire logic daa_zf = daa_res == 8'h00;
  wire logic daa_pf = ~^daa_res;
  wire logic das_zf = das_res == 8'h00;
  wire logic das_pf = ~^das_res;

  //////////////////////////////////////////////////////////////////////
  // minus one

  wire logic [31:0] dec_full = opnd_r - 32'h0000_0001;
  wire logic dec_w32 = ~dec_byte & cmd_w.size32;
  wire logic dec_w16 = ~dec_byte & ~cmd_w.size32;
  wire logic [31:0] dec_wb =
    dec_w32 ? dec_full :
    dec_w16 ? {opnd_r[31:16], dec_full[15:0]} :
    {opnd_r[31:8], dec_full[7:0]};
  wire logic dec_zf = dec_w32 ? dec_full == 32'h0000_0000 :
                      dec_w16 ? dec_full[15:0] == 16'h0000 :
                      dec_full[7:0] == 8'h00;
  wire logic dec_sf = dec_w32 ? dec_full[31] :
                      dec_w16 ? dec_full[15] : dec_full[7];
  // overflow only when stepping from the most negative value
  wire logic dec_of = dec_w32 ? opnd_r == 32'h8000_0000 :
                      dec_w16 ? opnd_r[15:0] == 16'h8000 :
                      opnd_r[7:0] == 8'h80;
  // aux carry here is a borrow out of the low nibble
  wire logic dec_af = opnd_r[3:0] == 4'h0;
  wire logic dec_pf = ~^dec_full[7:0];

  //////////////////////////////////////////////////////////////////////
  // fault checks of the minus-one memory operand

  wire logic m_prot = ctx_r.mode == `SBD_MODE_PROT;
  wire logic m_v86 = ctx_r.mode == `SBD_MODE_V86;
  wire logic f_gp = dec_mem & ((m_prot & ctx_r.nonwr) |
                               ctx_r.cds_lim |
                               (m_prot & ctx_r.null_sel));
  wire logic f_ss = dec_mem & ctx_r.ss_lim;
  wire logic f_pf = dec_mem & ctx_r.pf_hit & (m_prot | m_v86);
  wire logic f_ac = dec_mem & ctx_r.ac_en & ctx_r.unaligned &
                    ((m_prot & ctx_r.cpl == `SBD_CPL_USER) | m_v86);
  // report only the highest priority fault: gp, ss, pf, ac
  wire logic r_gp = f_gp;
  wire logic r_ss = f_ss & ~f_gp;
  wire logic r_pf = f_pf & ~f_gp & ~f_ss;
  wire logic r_ac = f_ac & ~f_gp & ~f_ss & ~f_pf;
  wire logic any_fault = f_gp | f_ss | f_pf | f_ac;
  wire logic [15:0] f_code = r_pf ? ctx_r.pf_code : `SBD_GP_CODE;

  //////////////////////////////////////////////////////////////////////
  // status word as software writes it

  // bits outside the mask, other than the query bit, are reserved and always read back as zero
  wire logic [31:0] flg_keep = flags_r & ~`SBD_FLG_WMASK;
  wire logic [31:0] flg_soft = (pwdata & `SBD_FLG_WMASK) | flg_keep;
  // an older core without the query instruction keeps this bit at zero
  wire logic id_soft = FEATURE_QUERY_IMPL & pwdata[`SBD_FLG_ID];

  //////////////////////////////////////////////////////////////////////
  // next values

  always_comb begin
    acc_nxt = acc_r;
    ext_nxt = ext_r;
    opnd_nxt = opnd_r;
    flags_nxt = flags_r;
    fault_nxt = fault_r;
    if (wr_acc) begin
      acc_nxt = pwdata;
    end
    if (wr_ext) begin
      ext_nxt = pwdata;
    end
    if (wr_opnd) begin
      opnd_nxt = pwdata;
    end
    if (wr_flags) begin
      flags_nxt = flg_soft;
      flags_nxt[`SBD_FLG_ID] = id_soft;
    end
    if (exec) begin
      fault_nxt = '0;
      fault_nxt.done = 1'b1;
      unique case (op_sel)
        SBD_OP_NONE: begin
          fault_nxt.undef = 1'b1;
        end
        SBD_OP_WIDEN: begin
          ext_nxt = widen_ext;
        end
        SBD_OP_DAA: begin
          acc_nxt = {acc_r[31:8], daa_res};
          flags_nxt[`SBD_FLG_CF] = daa_hi_fix;
          flags_nxt[`SBD_FLG_AF] = lo_fix;
          flags_nxt[`SBD_FLG_SF] = daa_res[7];
          flags_nxt[`SBD_FLG_ZF] = daa_zf;
          flags_nxt[`SBD_FLG_PF] = daa_pf;
        end
        SBD_OP_DAS: begin
          acc_nxt = {acc_r[31:8], das_res};
          flags_nxt[`SBD_FLG_CF] = das_hi_fix;
          flags_nxt[`SBD_FLG_AF] = lo_fix;
          flags_nxt[`SBD_FLG_SF] = das_res[7];
          flags_nxt[`SBD_FLG_ZF] = das_zf;
          flags_nxt[`SBD_FLG_PF] = das_pf;
        end
        SBD_OP_DEC: begin
          if (any_fault) begin
            // operand and flags stay put so the op can restart
            fault_nxt.gp = r_gp;
            fault_nxt.ss = r_ss;
            fault_nxt.pf = r_pf;
            fault_nxt.ac = r_ac;
            fault_nxt.code = f_code;
          end else begin
            opnd_nxt = dec_wb;
            flags_nxt[`SBD_FLG_OF] = dec_of;
            flags_nxt[`SBD_FLG_SF] = dec_sf;
            flags_nxt[`SBD_FLG_ZF] = dec_zf;
            flags_nxt[`SBD_FLG_AF] = dec_af;
            flags_nxt[`SBD_FLG_PF] = dec_pf;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers

  // one short process per register keeps each reset value in view
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 32'h0000_0000;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_r <= 32'h0000_0000;
    end else begin
      ext_r <= ext_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opnd_r <= 32'h0000_0000;
    end else begin
      opnd_r <= opnd_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= `SBD_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // the command word is kept for read back only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= '0;
    end else if (exec) begin
      cmd_r <= cmd_w;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctx_r <= '0;
    end else if (wr_ctx) begin
      ctx_r <= pwdata;
    end
  end

  // read data is caught at setup; nothing changes during the access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : sbd_core

// *** sbd_core_chk.sv ***
// apb-level assertions for the sign widen / bcd / minus-one slice
// assumes it sees only the top ports; the bind sits at the foot
`timescale 1ns/1ns
module sbd_core_chk
  import sbd_pkg::*;
#(
  parameter logic FEATURE_QUERY_IMPL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////
  // shadow of the operands staged before the last command
  logic [31:0] acc_r, opnd_r, flg_r, ctx_r, cmd_r;
  logic ok_r;
  wire xfer_w = psel && penable && pready;
  wire rd_w = xfer_w && !pwrite;
  wire [31:0] fmask_w = {10'h0, FEATURE_QUERY_IMPL, 21'h0008d5};
  wire wid_w = ok_r && cmd_r[7:0] == 8'h99;
  wire bcd_w = ok_r && (cmd_r[7:0] == 8'h27 || cmd_r[7:0] == 8'h2f);
  wire dec_w = ok_r && cmd_r[12:0] == 13'h09ff;
  wire gp_w = ok_r && cmd_r[12:0] == 13'h19ff && ctx_r[2:0] == 3'h5;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {acc_r, opnd_r, flg_r, ctx_r, cmd_r, ok_r} <= '0;
    end else if (xfer_w && pwrite) begin
      if (paddr == 12'h004) acc_r <= pwdata;
      if (paddr == 12'h00c) opnd_r <= pwdata;
      if (paddr == 12'h010) flg_r <= pwdata & fmask_w;
      if (paddr == 12'h014) ctx_r <= pwdata;
      if (paddr == 12'h000) cmd_r <= pwdata;
      // a second command leaves the shadow stale, so stop checking
      ok_r <= paddr == 12'h000 && !ok_r;
    end
  end
  //////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_answer;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("late apb answer");
  property p_w16;
    rd_w && paddr == 12'h008 && wid_w && !cmd_r[11] |->
      prdata[15:0] == {16{acc_r[15]}};
  endproperty
  a_w16: assert property (p_w16) else $error("bad word widen");
  property p_w32;
    rd_w && paddr == 12'h008 && wid_w && cmd_r[11] |->
      prdata == {32{acc_r[31]}};
  endproperty
  a_w32: assert property (p_w32) else $error("bad dword widen");
  property p_wflg;
    rd_w && paddr == 12'h010 && wid_w |-> prdata == flg_r;
  endproperty
  a_wflg: assert property (p_wflg) else $error("widen moved flags");
  property p_nofault;
    rd_w && paddr == 12'h018 && (wid_w || bcd_w) |-> prdata[4:0] == 5'h0;
  endproperty
  a_nofault: assert property (p_nofault) else $error("fault seen");
  property p_bcdhi;
    rd_w && paddr == 12'h004 && bcd_w |-> prdata[31:8] == acc_r[31:8];
  endproperty
  a_bcdhi: assert property (p_bcdhi) else $error("upper acc hit");
  property p_dec;
    rd_w && paddr == 12'h00c && dec_w |-> prdata == opnd_r - 32'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("bad minus one");
  property p_deccf;
    rd_w && paddr == 12'h010 && dec_w |-> prdata[0] == flg_r[0];
  endproperty
  a_deccf: assert property (p_deccf) else $error("carry moved");
  property p_gp;
    rd_w && paddr == 12'h018 && gp_w |-> prdata[0] && !(|prdata[31:16]);
  endproperty
  a_gp: assert property (p_gp) else $error("no protection fault");
  property p_keep;
    rd_w && paddr == 12'h00c && gp_w |-> prdata == opnd_r;
  endproperty
  a_keep: assert property (p_keep) else $error("operand changed");
endmodule : sbd_core_chk

bind sbd_core sbd_core_chk #(.FEATURE_QUERY_IMPL(FEATURE_QUERY_IMPL)) u_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// *** sbd_core_tb.sv ***
// self-checking bench for sbd_core driven over apb
// assumes sbd_core_chk binds itself into the design
`timescale 1ns/1ns
module sbd_core_tb
  import sbd_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [64:0] note_q[$];
  logic [64:0] note;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 56216;
  logic [31:0] acc, ext, opnd, flg, ctx, e_acc, e_ext, e_opnd, e_flg, e_flt;
  logic [31:0] ovals [4] = '{32'h0, 32'h8000_8000, 32'h0001_0001, 32'h80};
  logic [31:0] cmds [11] = '{32'h099, 32'h899, 32'h027, 32'h02f, 32'h1fe,
    32'h1ff, 32'h9ff, 32'h04a, 32'h84f, 32'h0fe, 32'h1027};
  logic [63:0] fcase [14] = '{{32'h19ff, 32'h5}, {32'h19ff, 32'h11},
    {32'h19ff, 32'h4}, {32'h19ff, 32'h8}, {32'h19ff, 32'h20},
    {32'h19ff, 32'h28}, {32'h19ff, 32'hbeef_0401}, {32'h19ff, 32'h400},
    {32'h19ff, 32'h242}, {32'h19ff, 32'h3c1}, {32'h19ff, 32'h241},
    {32'h19ff, 32'h240}, {32'h11fe, 32'h5}, {32'h184b, 32'h5}};
  sbd_core #(.FEATURE_QUERY_IMPL(1'b1)) u_dut (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // the monitor pairs each completed read with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      note = note_q.pop_front();
      check({pslverr, prdata & note[63:32]},
            {note[64], note[31:0] & note[63:32]});
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    note_q.push_back({a > 12'h018, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // stage operands, execute, and predict acc, ext, opnd, flags and fault afterwards
  task automatic run(input logic [31:0] c);
    logic [7:0] al;
    logic cf, af, upd;
    logic [31:0] wm, r;
    logic [1:0] m;
    apb(1'b1, 12'h004, acc);
    apb(1'b1, 12'h008, ext);
    apb(1'b1, 12'h00c, opnd);
    apb(1'b1, 12'h010, flg);
    apb(1'b1, 12'h014, ctx);
    apb(1'b1, 12'h000, c);
    {e_acc, e_ext, e_opnd, e_flt} = {acc, ext, opnd, 32'h0};
    e_flg = flg & 32'h0020_08d5;
    {al, cf, af, m, upd} = {acc[7:0], flg[0], flg[4], ctx[1:0], 1'b0};
    wm = c[11] ? 32'hffff_ffff : 32'h0000_ffff;
    if (c[7:0] == 8'h99) begin
      e_ext = c[11] ? {32{acc[31]}} : {ext[31:16], {16{acc[15]}}};
    end else if (c[7:0] == 8'h27 || c[7:0] == 8'h2f) begin
      af = al[3:0] > 4'h9 || af;
      if (af) cf = cf | (c[3] ? al < 8'h06 : al > 8'hf9);
      if (af) al = c[3] ? al - 8'h06 : al + 8'h06;
      cf = cf || (c[3] ? al > 8'h9f : al[7:4] > 4'h9);
      if (cf) al = c[3] ? al - 8'h60 : al + 8'h60;
      {e_acc[7:0], e_flg[0], e_flg[4], r, wm, upd} = {al, cf, af,
        24'h0, al, 32'hff, 1'b1};
    end else if ((c[7:1] == 7'h7f && c[10:8] == 3'h1) || c[7:3] == 5'h09) begin
      if (c[7:0] == 8'hfe) wm = 32'hff;
      if (c[12] && c[7:3] != 5'h09) begin
        if ((m == 2'h1 && (ctx[2] || ctx[4])) || ctx[3]) e_flt = 32'h1;
        else if (ctx[5]) e_flt = 32'h2;
        else if (m != 2'h0 && ctx[10]) e_flt = {ctx[31:16], 16'h4};
        else if (ctx[6] && ctx[9] && (m == 2'h2 ||
          (m == 2'h1 && ctx[8:7] == 2'h3))) e_flt = 32'h8;
      end
      if (e_flt == 32'h0) begin
        r = (opnd - 32'h1) & wm;
        e_opnd = (opnd & ~wm) | r;
        e_flg[11] = (opnd & wm) == (~(wm >> 1) & wm);
        e_flg[4] = opnd[3:0] == 4'h0;
        upd = 1'b1;
      end
    end else e_flt = 32'h10;
    if (upd) {e_flg[7], e_flg[6], e_flg[2]} = {|(r & ~(wm >> 1) & wm),
      r == 32'h0, ~^r[7:0]};
    rd(12'h004, e_acc);
    rd(12'h008, e_ext);
    rd(12'h00c, e_opnd);
    rd(12'h010, e_flg);
    rd(12'h018, e_flt, ~32'h20);
  endtask : run
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(12'h010, 32'h0);
    apb(1'b1, 12'h018, 32'hffff_ffff);
    rd(12'h018, 32'h0);
    rd(12'h01c, 32'h0);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    rd(12'h010, 32'h0020_08d5);
    apb(1'b1, 12'h010, 32'h0);
    rd(12'h010, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 88; i++) begin
      {acc, ext, flg, ctx} = {$random(seed), $random(seed), $random(seed),
        32'h0};
      opnd = ovals[i % 4];
      if (i % 4 == 0) opnd = $random(seed);
      run(cmds[i % 11]);
    end
    $display("test operations done");
    foreach (fcase[k]) begin
      {acc, ext, opnd, flg} = {$random(seed), $random(seed), $random(seed),
        $random(seed)};
      ctx = fcase[k][31:0];
      run(fcase[k][63:32]);
    end
    $display("test faults done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule : sbd_core_tb

// *** sbd_pkg.sv ***
// types of the sign-widen / bcd-adjust / minus-one slice
// assumes sbd_regs_regs.svh holds the numeric constants
package sbd_pkg;

  typedef struct packed {
    logic [18:0] rsv;
    logic mem;
    logic size32;
    logic [2:0] reg_fld;
    logic [7:0] opcode;
  } sbd_cmd_type;

  typedef struct packed {
    logic [15:0] pf_code;
    logic [4:0] rsv;
    logic pf_hit;
    logic unaligned;
    logic [1:0] cpl;
    logic ac_en;
    logic ss_lim;
    logic null_sel;
    logic cds_lim;
    logic nonwr;
    logic [1:0] mode;
  } sbd_ctx_type;

  typedef struct packed {
    logic [15:0] code;
    logic [9:0] rsv;
    logic done;
    logic undef;
    logic ac;
    logic pf;
    logic ss;
    logic gp;
  } sbd_fault_type;

  typedef enum logic [4:0] {
    SBD_OP_NONE = 5'b00001,
    SBD_OP_WIDEN = 5'b00010,
    SBD_OP_DAA = 5'b00100,
    SBD_OP_DAS = 5'b01000,
    SBD_OP_DEC = 5'b10000
  } sbd_op_type;

endpackage : sbd_pkg

// *** sbd_regs_regs.svh ***
// constants of the sign-widen / bcd-adjust / minus-one slice
// assumes a 12-bit apb byte address and 32-bit data
`ifndef SBD_REGS_REGS_SVH
`define SBD_REGS_REGS_SVH
`define SBD_ADDR_CMD 12'h000
`define SBD_ADDR_ACC 12'h004
`define SBD_ADDR_EXT 12'h008
`define SBD_ADDR_OPND 12'h00c
`define SBD_ADDR_FLAGS 12'h010
`define SBD_ADDR_CTX 12'h014
`define SBD_ADDR_FAULT 12'h018
`define SBD_OPC_WIDEN 8'h99
`define SBD_OPC_DAA 8'h27
`define SBD_OPC_DAS 8'h2f
`define SBD_OPC_DEC_B 8'hfe
`define SBD_OPC_DEC_V 8'hff
`define SBD_OPC_DEC_R 5'h09
`define SBD_MODRM_DEC 3'h1
`define SBD_FLG_CF 0
`define SBD_FLG_PF 2
`define SBD_FLG_AF 4
`define SBD_FLG_ZF 6
`define SBD_FLG_SF 7
`define SBD_FLG_OF 11
`define SBD_FLG_ID 21
`define SBD_FLG_WMASK 32'h0000_08d5
`define SBD_FLAGS_RST 32'h0000_0000
`define SBD_DIGIT_MAX 4'h9
`define SBD_LO_ADJ 8'h06
`define SBD_HI_ADJ 8'h60
`define SBD_HI_MASK 8'hf0
`define SBD_DAA_HI_MAX 8'h90
`define SBD_DAS_HI_MAX 8'h9f
`define SBD_MODE_REAL 2'h0
`define SBD_MODE_PROT 2'h1
`define SBD_MODE_V86 2'h2
`define SBD_CPL_USER 2'h3
`define SBD_GP_CODE 16'h0000
`endif
